/* design/hfc_pkg.sv */
package hfc_pkg;
    // FIFO geometry
    localparam int DEPTH = 64;
    localparam int AW = 6;
    localparam int CW = 7;
    localparam logic [CW-1:0] FULL_CNT = 7'h40;

    // Register offsets
    localparam logic [3:0] A_CFG = 4'h0;
    localparam logic [3:0] A_TXCTL = 4'h1;
    localparam logic [3:0] A_TXSTAT = 4'h2;
    localparam logic [3:0] A_DATA = 4'h3;
    localparam logic [3:0] A_RXSTAT = 4'h4;
    localparam logic [3:0] A_RXCTL = 4'h5;
    localparam logic [3:0] A_RESET = 4'h6;
    localparam logic [3:0] A_MASK = 4'hE;
    localparam logic [3:0] A_STATUS = 4'hF;

    // Field positions
    localparam int B_LEVEL = 0;
    localparam int B_POL = 1;
    localparam int B_TRANSP = 2;
    localparam int B_TXLAST = 7;
    localparam int B_TXABT = 6;
    localparam int B_LIVE = 7;
    localparam int B_FEP = 7;
    localparam int B_TXRES = 5;
    localparam int B_RXRES = 4;

    // Status bit positions
    localparam int S_TXDONE = 0;
    localparam int S_TXSP = 1;
    localparam int S_UNDR = 2;
    localparam int S_RXLVL = 3;
    localparam int S_RXEOF = 4;
    localparam int S_IDLE = 5;
    localparam int S_OVR = 6;
    localparam logic [6:0] TX_BITS = 7'h07;
    localparam logic [6:0] RX_BITS = 7'h78;
    localparam logic [6:0] LVL_BITS = 7'h0A;

    // Values after reset; overrun status byte
    localparam logic [5:0] TXTHR_RST = 6'h20;
    localparam logic [5:0] RXTHR_RST = 6'h20;
    localparam logic [6:0] MASK_RST = 7'h00;
    localparam logic [6:0] STATUS_RST = 7'h00;
    localparam logic [7:0] OVR_STATUS = 8'h80;

    typedef struct packed {
        logic transparent;
        logic request_polarity;
        logic level_clear_mode;
    } hfc_cfg_t;

    localparam hfc_cfg_t CFG_RST = 3'h0;

    // Transmit entry: frame mark in the MSB
    typedef struct packed {
        logic tx_frame_last;
        logic tx_frame_abort;
        logic [7:0] data;
    } hfc_tx_ent_t;

    // Receive entry: status-byte mark in the MSB
    typedef struct packed {
        logic frame_status_byte;
        logic [7:0] data;
    } hfc_rx_ent_t;
endpackage

/* design/hfc_fifo.sv */
`timescale 1ns/100ps
module hfc_fifo #(
    parameter int W = 8
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic clr,
    // Write side
    input wire logic push,
    input wire logic [W-1:0] din,
    // Read side
    input wire logic pop,
    output logic [W-1:0] dout,
    // Fill state
    output logic [hfc_pkg::CW-1:0] count,
    output logic mark_found,
    output logic [hfc_pkg::CW-1:0] mark_len
);
    import hfc_pkg::*;

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] rp, wp, next_rp, next_wp, waddr;
    logic [CW-1:0] next_count;
    logic full, do_pop, do_push, ovw;

    // Pointer arithmetic; a push into a full FIFO rewrites the newest entry
    always_comb begin
        full = (count == FULL_CNT);
        do_pop = pop && (count != '0);
        ovw = push && full && !do_pop;
        do_push = push && (!full || do_pop);
        waddr = ovw ? wp - 6'h01 : wp;
        next_rp = rp + AW'(do_pop);
        next_wp = wp + AW'(do_push);
        next_count = count + CW'(do_push) - CW'(do_pop);
        if (clr) begin
            next_rp = '0;
            next_wp = '0;
            next_count = '0;
        end
        dout = mem[rp];
    end

    // Distance to the first marked entry, inclusive; whole count if none
    always_comb begin
        mark_found = 1'b0;
        mark_len = count;
        for (int i = 0; i < DEPTH; i++) begin
            if (!mark_found && CW'(i) < count && mem[rp + AW'(i)][W-1]) begin
                mark_found = 1'b1;
                mark_len = CW'(i + 1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rp <= '0;
            wp <= '0;
            count <= '0;
        end else if (ce) begin
            rp <= next_rp;
            wp <= next_wp;
            count <= next_count;
        end
    end

    // Storage has no reset; pointers alone define validity
    always_ff @(posedge clk) begin
        if (ce && push && !clr) begin
            mem[waddr] <= din;
        end
    end
endmodule

/* design/hfc_ctrl.sv */
// Notes on behaviour
// - Request pin polarity set by software bit
// - Request asserts on first unmasked, holds until read
// - Event during status read re-asserts request
// - Masking or unmasking updates request immediately
// - Status records conditions regardless of mask
// - Edge mode: status read clears bits
// - Level mode: space/level bits follow cause
// - Live transmit-space copy in transmit status
// - Unframed mode suppresses frame-end, underrun and idle events; frame-done reports drain or underrun
// - Full reset by pin or both bits
// - Outputs off in reset, request inactive after
// - Transmit reset clears FIFO, sets space flag
// - Receive reset clears FIFO and receive flags
// - 64-byte transmit FIFO with frame marks
// - Transmit status reports free byte count
// - Space flag at programmed free threshold
// - Frame-done and underrun transmit events
// - Write to full FIFO overwrites newest byte
// - Status byte per frame, queue count
// - Level flag at programmed fill threshold
// - Receive overrun replaces last byte, raises event
// - Frame-end and idle receive events
`timescale 1ns/100ps
module hfc_ctrl (
    // Clock, reset, enable
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CE,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Service request pin
    output logic INT_OUT,
    output logic INT_OE,
    // Transmit engine side
    input wire logic TX_POP,
    output logic TX_READY,
    output logic [7:0] TX_DATA,
    output logic TX_LAST,
    output logic TX_ABORT,
    input wire logic TX_FRAME_DONE,
    input wire logic TX_UNDERRUN,
    output logic TX_RESET,
    // Receive engine side
    input wire logic RX_WR,
    input wire logic RX_MARK,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_IDLE,
    output logic RX_RESET
);
    import hfc_pkg::*;

    // Register decode for one access strobe
    function automatic logic hit(input logic stb, input logic [3:0] a,
                                 input logic [3:0] off);
        hit = stb && (a == off);
    endfunction

    // Software-visible state
    hfc_cfg_t cfg, next_cfg;
    logic [5:0] tx_thr, next_tx_thr, rx_thr, next_rx_thr;
    logic tx_last_bit, next_tx_last_bit, tx_abt_bit, next_tx_abt_bit;
    logic [6:0] mask, next_mask, status, next_status;
    logic tx_cond_q, next_tx_cond_q, rx_cond_q, next_rx_cond_q;
    logic [7:0] next_rdata;
    logic next_int_out;
    logic next_tx_reset, next_rx_reset;

    // Transmit output stage
    logic next_tx_ready;
    logic [7:0] next_tx_data;
    logic next_tx_last, next_tx_abort;

    // Decoded strobes and derived conditions
    logic full_rst, tx_rst, rx_rst;
    logic wr_reset, wr_data, rd_data, rd_status;
    logic tx_push, tx_pop, rx_push, rx_pop;
    logic tx_cond, rx_cond, rx_full, tx_empty_ev;
    logic [6:0] ev, clr_bits;
    logic [CW-1:0] tx_cnt, tx_free, rx_cnt, rx_qlen;
    logic rx_fep;
    hfc_tx_ent_t tx_din, tx_dout;
    hfc_rx_ent_t rx_din, rx_dout;
    logic rx_found_w;
    logic [CW-1:0] rx_qlen_w;

    // Status-byte presence as seen by the receive status register
    function automatic logic rx_mark_found();
        rx_mark_found = rx_found_w;
    endfunction

    // Access decode and reset requests
    always_comb begin
        wr_reset = hit(WR, ADDR, A_RESET);
        wr_data = hit(WR, ADDR, A_DATA);
        rd_data = hit(RD, ADDR, A_DATA);
        rd_status = hit(RD, ADDR, A_STATUS);
        full_rst = wr_reset && WDATA[B_TXRES] && WDATA[B_RXRES];
        tx_rst = full_rst || (wr_reset && WDATA[B_TXRES] && !WDATA[B_RXRES]);
        rx_rst = full_rst || (wr_reset && !WDATA[B_TXRES] && WDATA[B_RXRES]);
    end

    // FIFO traffic; the engine may only pop while TX_READY stands
    always_comb begin
        tx_push = wr_data;
        tx_din = '{tx_frame_last: tx_last_bit, tx_frame_abort: tx_abt_bit,
                   data: WDATA};
        tx_pop = TX_POP && TX_READY;
        tx_free = FULL_CNT - tx_cnt;
        rx_pop = rd_data;
        rx_push = RX_WR;
        rx_full = (rx_cnt == FULL_CNT) && !rx_pop;
        // Overrun stamps the newest slot with an overrun status byte
        if (rx_full) begin
            rx_din = '{frame_status_byte: 1'b1, data: OVR_STATUS};
        end else begin
            rx_din = '{frame_status_byte: RX_MARK && !cfg.transparent,
                       data: RX_DATA};
        end
        rx_fep = rx_mark_found();
        rx_qlen = rx_qlen_w;
    end

    // Transmit FIFO; full writes rewrite the newest byte silently
    hfc_fifo #(.W($bits(hfc_tx_ent_t))) u_txq (
        .clk(MCLK),
        .rst(RST),
        .ce(CE),
        .clr(tx_rst),
        .push(tx_push),
        .din(tx_din),
        .pop(tx_pop),
        .dout(tx_dout),
        .count(tx_cnt),
        .mark_found(),
        .mark_len()
    );

    // Receive FIFO; marks are the per-frame status bytes
    hfc_fifo #(.W($bits(hfc_rx_ent_t))) u_rxq (
        .clk(MCLK),
        .rst(RST),
        .ce(CE),
        .clr(rx_rst),
        .push(rx_push),
        .din(rx_din),
        .pop(rx_pop),
        .dout(rx_dout),
        .count(rx_cnt),
        .mark_found(rx_found_w),
        .mark_len(rx_qlen_w)
    );

    // Conditions and one-cycle events feeding the status register
    always_comb begin
        tx_cond = tx_free >= {1'b0, tx_thr};
        rx_cond = rx_cnt >= {1'b0, rx_thr};
        tx_empty_ev = tx_pop && (tx_cnt == 7'h01) && !tx_push;
        ev = '0;
        if (cfg.transparent) begin
            // Unframed: frame-done reports both drain and underrun
            ev[S_TXDONE] = TX_UNDERRUN || tx_empty_ev;
        end else begin
            ev[S_TXDONE] = TX_FRAME_DONE;
            ev[S_UNDR] = TX_UNDERRUN;
            ev[S_RXEOF] = rx_push && RX_MARK && !rx_full;
            ev[S_IDLE] = RX_IDLE;
        end
        ev[S_OVR] = rx_push && rx_full;
        // Edge mode needs the cause to go away and come back
        ev[S_TXSP] = tx_cond && !tx_cond_q;
        ev[S_RXLVL] = rx_cond && !rx_cond_q;
        if (rd_status) begin
            clr_bits = cfg.level_clear_mode ? ~LVL_BITS : 7'h7F;
        end else begin
            clr_bits = '0;
        end
    end

    // Next state of the register file and request pin
    always_comb begin
        next_cfg = cfg;
        next_tx_thr = tx_thr;
        next_rx_thr = rx_thr;
        next_tx_last_bit = tx_last_bit;
        next_tx_abt_bit = tx_abt_bit;
        next_mask = mask;
        next_tx_cond_q = tx_cond;
        next_rx_cond_q = rx_cond;
        if (hit(WR, ADDR, A_CFG)) begin
            next_cfg = '{transparent: WDATA[B_TRANSP],
                         request_polarity: WDATA[B_POL],
                         level_clear_mode: WDATA[B_LEVEL]};
        end
        if (hit(WR, ADDR, A_TXCTL)) begin
            next_tx_last_bit = WDATA[B_TXLAST];
            next_tx_abt_bit = WDATA[B_TXABT] && !cfg.transparent;
            next_tx_thr = WDATA[5:0];
        end else if (tx_push) begin
            // Marks apply to one byte only
            next_tx_last_bit = 1'b0;
            next_tx_abt_bit = 1'b0;
        end
        if (hit(WR, ADDR, A_RXCTL)) begin
            next_rx_thr = WDATA[5:0];
        end
        if (hit(WR, ADDR, A_MASK)) begin
            next_mask = WDATA[6:0];
        end
        // Set wins over a read clear, so nothing is lost in the read cycle
        next_status = (status & ~clr_bits) | ev;
        if (cfg.level_clear_mode) begin
            next_status[S_TXSP] = tx_cond;
            next_status[S_RXLVL] = rx_cond;
        end
        if (tx_rst) begin
            next_status = (next_status & ~TX_BITS) | 7'h02;
        end
        if (rx_rst) begin
            next_status = next_status & ~RX_BITS;
        end
        if (full_rst) begin
            next_cfg = CFG_RST;
            next_tx_thr = TXTHR_RST;
            next_rx_thr = RXTHR_RST;
            next_tx_last_bit = 1'b0;
            next_tx_abt_bit = 1'b0;
            next_mask = MASK_RST;
            next_status = STATUS_RST;
            // Same edge history as the reset pin leaves behind
            next_tx_cond_q = 1'b1;
            next_rx_cond_q = 1'b0;
        end
        // Level of the pin is a pure function of flags, mask and polarity
        next_int_out = |(next_status & next_mask);
        if (!next_cfg.request_polarity) begin
            next_int_out = !next_int_out;
        end
        next_tx_reset = tx_rst;
        next_rx_reset = rx_rst;
    end

    // Read data, valid only in the cycle after the strobe
    always_comb begin
        next_rdata = '0;
        if (RD) begin
            case (ADDR)
                A_CFG: next_rdata = {5'h00, cfg};
                A_TXCTL: next_rdata = {tx_last_bit, tx_abt_bit, tx_thr};
                A_TXSTAT: next_rdata = {tx_cond, tx_free};
                A_DATA: next_rdata = rx_dout.data;
                A_RXSTAT: next_rdata = {rx_fep, rx_qlen};
                A_RXCTL: next_rdata = {2'h0, rx_thr};
                A_MASK: next_rdata = {1'b0, mask};
                A_STATUS: next_rdata = {1'b0, status};
                default: next_rdata = '0;
            endcase
        end
    end

    // Transmit output stage: a taken pop shows its byte next cycle
    always_comb begin
        next_tx_data = TX_DATA;
        next_tx_last = TX_LAST;
        next_tx_abort = TX_ABORT;
        if (tx_pop) begin
            next_tx_data = tx_dout.data;
            next_tx_last = tx_dout.tx_frame_last;
            next_tx_abort = tx_dout.tx_frame_abort;
        end
        // Conservative: one idle cycle after popping the last byte
        next_tx_ready = (tx_cnt > 7'h01) || (tx_cnt == 7'h01 && !tx_pop);
        if (tx_rst) begin
            next_tx_ready = 1'b0;
        end
    end

    // Register file; CE low freezes everything
    always_ff @(posedge MCLK) begin
        if (RST) begin
            cfg <= CFG_RST;
            tx_thr <= TXTHR_RST;
            rx_thr <= RXTHR_RST;
            tx_last_bit <= 1'b0;
            tx_abt_bit <= 1'b0;
            mask <= MASK_RST;
            status <= STATUS_RST;
            // Space is free out of reset; a low start would fake a rising edge
            tx_cond_q <= 1'b1;
            rx_cond_q <= 1'b0;
        end else if (CE) begin
            cfg <= next_cfg;
            tx_thr <= next_tx_thr;
            rx_thr <= next_rx_thr;
            tx_last_bit <= next_tx_last_bit;
            tx_abt_bit <= next_tx_abt_bit;
            mask <= next_mask;
            status <= next_status;
            tx_cond_q <= next_tx_cond_q;
            rx_cond_q <= next_rx_cond_q;
        end
    end

    // Read port: data stand one cycle, zero otherwise
    always_ff @(posedge MCLK) begin
        if (RST) begin
            RDATA <= 8'h00;
        end else if (CE) begin
            RDATA <= next_rdata;
        end
    end

    // Request pin stays undriven while the reset pin is held
    always_ff @(posedge MCLK) begin
        if (RST) begin
            INT_OUT <= 1'b1;
            INT_OE <= 1'b0;
        end else if (CE) begin
            INT_OUT <= next_int_out;
            INT_OE <= 1'b1;
        end
    end

    // Engine side outputs and one-cycle direction reset pulses
    always_ff @(posedge MCLK) begin
        if (RST) begin
            TX_READY <= 1'b0;
            TX_DATA <= 8'h00;
            TX_LAST <= 1'b0;
            TX_ABORT <= 1'b0;
            TX_RESET <= 1'b0;
            RX_RESET <= 1'b0;
        end else if (CE) begin
            TX_READY <= next_tx_ready;
            TX_DATA <= next_tx_data;
            TX_LAST <= next_tx_last;
            TX_ABORT <= next_tx_abort;
            TX_RESET <= next_tx_reset;
            RX_RESET <= next_rx_reset;
        end
    end
endmodule

/* testbench/hfc_ctrl_asserts.sv */
`timescale 1ns/100ps
module hfc_ctrl_asserts
    import hfc_pkg::*;
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // Request pin and engines
    input wire logic INT_OUT,
    input wire logic INT_OE,
    input wire logic TX_POP,
    input wire logic TX_READY,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_RESET,
    input wire logic RX_RESET
);
    logic pol;
    logic act;
    logic acc;
    logic rwr;
    // Tracks the active level so that a drop of the request can be told apart
    assign rwr = WR && ADDR == A_RESET;
    assign acc = WR || RD;
    assign act = INT_OUT == pol;
    always_ff @(posedge MCLK) begin
        if (RST || (rwr && WDATA[5:4] == 2'b11)) begin
            pol <= 1'b0;
        end else if (WR && ADDR == A_CFG) begin
            pol <= WDATA[B_POL];
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    // Pin behaviour around reset
    a_oe_off: assert property ($fell(RST) |-> !INT_OE)
        else $error("request pin driven in reset");
    a_oe_on: assert property ($fell(RST) |=> INT_OE && INT_OUT)
        else $error("request pin not inactive after reset");
    // Once active, the request drops only after a register access
    a_req_hold: assert property ($past(act) && !act |-> $past(acc) || $past(acc, 2))
        else $error("request dropped without access");
    // Soft resets
    a_full_reset: assert property (rwr && WDATA[5:4] == 2'b11 |=>
        TX_RESET && RX_RESET ##[1:2] INT_OUT) else $error("full soft reset wrong");
    a_tx_reset: assert property (rwr && WDATA[B_TXRES] |=> TX_RESET ##1 !TX_RESET)
        else $error("transmit reset pulse wrong");
    a_rx_reset: assert property (rwr && WDATA[B_RXRES] |=> RX_RESET ##1 !RX_RESET)
        else $error("receive reset pulse wrong");
    // Read data stand only after a read
    a_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
        else $error("read data outside read slot");
    // A pop while not ready is ignored
    a_pop_refused: assert property (TX_POP && !TX_READY && !WR |=> $stable(TX_DATA))
        else $error("refused pop changed data");
endmodule
bind hfc_ctrl hfc_ctrl_asserts i_hfc_ctrl_asserts (.MCLK, .RST, .ADDR, .WDATA, .WR, .RD,
    .RDATA, .INT_OUT, .INT_OE, .TX_POP, .TX_READY, .TX_DATA, .TX_RESET, .RX_RESET);

/* testbench/hfc_engine_model.sv */
`timescale 1ns/100ps
module hfc_engine_model (
    // Clock
    input wire logic MCLK,
    // Transmit side
    input wire logic TX_READY,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_LAST,
    input wire logic TX_ABORT,
    output logic TX_POP,
    output logic TX_FRAME_DONE,
    output logic TX_UNDERRUN,
    // Receive side
    output logic RX_WR,
    output logic RX_MARK,
    output logic [7:0] RX_DATA,
    output logic RX_IDLE
);
    logic pop_en = 1'b0;
    logic fast = 1'b1;
    logic pend = 1'b0;
    logic [9:0] got[$];
    initial begin
        {TX_POP, TX_FRAME_DONE, TX_UNDERRUN, RX_WR, RX_MARK, RX_IDLE} = 6'h00;
        RX_DATA = 8'hA5;
    end
    // Slow mode pops every other cycle; pops while not ready are sent anyway
    always @(posedge MCLK) begin
        if (pend) begin
            got.push_back({TX_LAST, TX_ABORT, TX_DATA});
        end
        pend <= TX_POP && TX_READY;
        TX_POP <= pop_en && (fast || !TX_POP);
    end
    // Released data lines show the inverse so stale values never look valid
    task automatic rx_put(input logic [7:0] d, input logic m);
        @(posedge MCLK);
        RX_WR <= 1'b1;
        RX_MARK <= m;
        RX_DATA <= d;
        @(posedge MCLK);
        RX_WR <= 1'b0;
        RX_MARK <= ~m;
        RX_DATA <= ~d;
    endtask
    // One-cycle event: 0 frame done, 1 underrun, 2 idle
    task automatic pulse(input int k);
        @(posedge MCLK);
        TX_FRAME_DONE <= k == 0;
        TX_UNDERRUN <= k == 1;
        RX_IDLE <= k == 2;
        @(posedge MCLK);
        {TX_FRAME_DONE, TX_UNDERRUN, RX_IDLE} <= 3'h0;
    endtask
endmodule

/* testbench/hfc_ctrl_tb_top.sv */
`timescale 1ns/100ps
module hfc_ctrl_tb_top;
    import hfc_pkg::*;
    logic MCLK = 1'b0;
    logic RST = 1'b1;
    logic [3:0] ADDR = 4'h0;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [7:0] RDATA, TX_DATA, RX_DATA, v;
    logic INT_OUT, INT_OE, TX_POP, TX_READY, TX_LAST, TX_ABORT, TX_RESET, RX_RESET;
    logic TX_FRAME_DONE, TX_UNDERRUN, RX_WR, RX_MARK, RX_IDLE;
    logic pol = 1'b0;
    logic [5:0] thr = 6'h20;
    int n_mismatch = 0;
    int n_tests = 0;
    int txq[$];
    int rxq[$];
    initial begin
        forever #20 MCLK = ~MCLK;
    end
    hfc_ctrl i_hfc_ctrl (.MCLK, .RST, .CE(1'b1), .ADDR, .WDATA, .WR, .RD, .RDATA, .INT_OUT,
        .INT_OE, .TX_POP, .TX_READY, .TX_DATA, .TX_LAST, .TX_ABORT, .TX_FRAME_DONE,
        .TX_UNDERRUN, .TX_RESET, .RX_WR, .RX_MARK, .RX_DATA, .RX_IDLE, .RX_RESET);
    hfc_engine_model i_hfc_engine_model (.MCLK, .TX_READY, .TX_DATA, .TX_LAST, .TX_ABORT,
        .TX_POP, .TX_FRAME_DONE, .TX_UNDERRUN, .RX_WR, .RX_MARK, .RX_DATA, .RX_IDLE);
    // Compare and count
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Bus cycles, one strobe cycle each
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge MCLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge MCLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge MCLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask
    // Reference model of both queues; a full queue overwrites its newest entry
    // Mark is {last, abort}; both self-clear after the byte
    task automatic push(input logic [7:0] d, input logic [1:0] m);
        if (m != 2'b00) wr(A_TXCTL, {m, thr});
        wr(A_DATA, d);
        if (txq.size() == DEPTH) void'(txq.pop_back());
        txq.push_back({m, d});
    endtask
    task automatic rx(input logic [7:0] d, input logic m);
        i_hfc_engine_model.rx_put(d, m);
        if (rxq.size() == DEPTH) rxq[DEPTH-1] = 8'h80;
        else rxq.push_back(d);
    endtask
    task automatic chk_tx();
        int free;
        free = DEPTH - txq.size();
        rd(A_TXSTAT, v);
        chk("tx_status", {free >= thr, 7'(free)}, v);
    endtask
    // Request pin settles a few cycles after its cause
    task automatic chk_int(input logic a);
        repeat (3) @(posedge MCLK);
        #1 chk("int_pin", {1'b1, a ~^ pol}, {INT_OE, INT_OUT});
    endtask
    task automatic drain_tx();
        i_hfc_engine_model.pop_en <= 1'b1;
        for (int i = 0; i < 300 && i_hfc_engine_model.got.size() < txq.size(); i++) begin
            @(posedge MCLK);
        end
        i_hfc_engine_model.pop_en <= 1'b0;
        if (i_hfc_engine_model.got.size() < txq.size()) begin
            n_mismatch++;
            tally_and_finish();
        end
        while (txq.size() > 0) chk("tx_byte", txq.pop_front(), i_hfc_engine_model.got.pop_front());
    endtask
    task automatic drain_rx();
        while (rxq.size() > 0) begin
            rd(A_DATA, v);
            chk("rx_byte", rxq.pop_front(), v);
        end
    endtask
    // Main sequence
    initial begin
        void'($urandom(38));
        repeat (20) @(posedge MCLK);
        RST <= 1'b0;
        for (int a = 0; a < 15; a++) begin
            if (a != 3) begin
                rd(4'(a), v);
                chk("reg", a == 1 || a == 5 ? 8'h20 : a == 2 ? 8'hC0 : 8'h00, v);
            end
        end
        $display("Test reset values done");
        thr = 6'h0A;
        wr(A_TXCTL, 8'h0A);
        for (int i = 0; i < 66; i++) begin
            push(8'($urandom), {i == 65, i == 30});
            chk_tx();
        end
        i_hfc_engine_model.fast <= 1'b0;
        drain_tx();
        chk_tx();
        $display("Test transmit fifo done");
        rd(A_STATUS, v);
        wr(A_MASK, 8'h02);
        wr(A_RESET, 8'h20);
        chk_int(1'b1);
        rd(A_STATUS, v);
        chk("status", 8'h02, v);
        chk_int(1'b0);
        rd(A_STATUS, v);
        chk("status", 8'h00, v);
        pol = 1'b1;
        wr(A_CFG, 8'h02);
        chk_int(1'b0);
        i_hfc_engine_model.pulse(0);
        chk_int(1'b0);
        wr(A_MASK, 8'h07);
        chk_int(1'b1);
        i_hfc_engine_model.pulse(1);
        wr(A_MASK, 8'h02);
        chk_int(1'b0);
        rd(A_STATUS, v);
        chk("status", 8'h05, v);
        wr(A_CFG, 8'h03);
        repeat (2) begin
            rd(A_STATUS, v);
            chk("status", 8'h02, v);
        end
        chk_int(1'b1);
        for (int i = 0; i < 60; i++) push(8'($urandom), 2'b00);
        chk_tx();
        rd(A_STATUS, v);
        chk("status", 8'h00, v);
        chk_int(1'b0);
        wr(A_RESET, 8'h20);
        txq.delete();
        $display("Test request modes done");
        pol = 1'b0;
        wr(A_CFG, 8'h00);
        wr(A_RXCTL, 8'h04);
        rd(A_STATUS, v);
        wr(A_MASK, 8'h18);
        for (int i = 0; i < 4; i++) rx(8'($urandom), i == 3);
        chk_int(1'b1);
        rd(A_RXSTAT, v);
        chk("rx_status", 8'h84, v);
        rd(A_STATUS, v);
        chk("status", 8'h18, v);
        i_hfc_engine_model.pulse(2);
        rd(A_STATUS, v);
        chk("status", 8'h20, v);
        drain_rx();
        for (int i = 0; i < 65; i++) rx(8'($urandom), 1'b0);
        rd(A_RXSTAT, v);
        chk("rx_status", 8'hC0, v);
        rd(A_STATUS, v);
        chk("overrun", 8'h40, v & 8'h40);
        drain_rx();
        rx(8'h11, 1'b0);
        wr(A_RESET, 8'h10);
        rxq.delete();
        rd(A_RXSTAT, v);
        chk("rx_status", 8'h00, v);
        chk_tx();
        $display("Test receive fifo done");
        wr(A_CFG, 8'h04);
        rd(A_STATUS, v);
        for (int k = 0; k < 3; k++) i_hfc_engine_model.pulse(k);
        rd(A_STATUS, v);
        chk("status", 8'h00, v & 8'h34);
        push(8'h5A, 2'b00);
        drain_tx();
        rd(A_STATUS, v);
        chk("done", 8'h01, v & 8'h01);
        $display("Test transparent mode done");
        wr(A_MASK, 8'h7F);
        wr(A_RESET, 8'h30);
        thr = 6'h20;
        chk_int(1'b0);
        rd(A_CFG, v);
        chk("cfg", 8'h00, v);
        rd(A_MASK, v);
        chk("mask", 8'h00, v);
        chk_tx();
        @(posedge MCLK);
        RST <= 1'b1;
        repeat (3) @(posedge MCLK);
        #1 chk("pin", 2'b01, {INT_OE, INT_OUT});
        @(posedge MCLK);
        RST <= 1'b0;
        chk_int(1'b0);
        $display("Test resets done");
        tally_and_finish();
    end
endmodule
